/* rtl/bdu_core.sv */
// Breakpoint and single-step debug unit: address, control and status registers.
`timescale 1ns/1ps
// Functional notes
// - Type field 00 execute, 01 data write, 11 data read or write; 10 unused.
// - Length field 00 one byte, 01 two bytes, 11 four bytes; 10 unused.
// - Global enable keeps a breakpoint live across task switches.
// - Local enable bits are cleared on every task switch.
// - Guard bit blocks register access and is cleared on any debug exception.
// - Each matching breakpoint sets its hit bit at exception, enabled or not.
// - Task-switch hit bit set at the next debug exception after switching into a task with trap bit.
// - Single-step hit bit set when the exception came from the trap flag.
// - Status is cleared only by reset; moves cannot write it, so software cannot clear it.
// - Trap flag set raises a debug exception after each completed instruction.
// - Four readable, writable 32-bit linear breakpoint address registers.
// - Status register is read-only to move accesses.
// - Breakpoint instruction raises a code breakpoint exception at that point.
// - Enabled breakpoint matching an access raises a debug exception.
// - Execute breakpoints are taken before the instruction executes.
// - Register moves allowed only at privilege level zero; real mode counts as zero.
module bdu_core
	import bdu_pkg::*;
#(
	parameter int AW = 32
) (
	input wire logic mclk,
	input wire logic srst,
	// Privileged move port
	input wire logic mov_valid,
	input wire logic mov_write,
	input wire logic [2:0] mov_sel,
	input wire logic [31:0] mov_wdata,
	input wire logic [1:0] cur_cpl,
	input wire logic real_mode,
	output logic [31:0] mov_rdata,
	output logic mov_fault,
	// Core access stream
	input wire logic acc_valid,
	input wire logic [1:0] acc_kind,
	input wire logic [AW-1:0] acc_addr,
	// Instruction events
	input wire logic insn_done,
	input wire logic [31:0] flags_register,
	input wire logic bp_insn_exec,
	input wire logic task_switch,
	input wire logic new_task_trap,
	// Exception requests to the core
	output logic dbg_exc_before,
	output logic dbg_exc_after,
	output logic bp_insn_exc
);
	logic [AW-1:0] addr_q [BDU_NUM_BP];
	logic [31:0] ctl_q;
	logic [31:0] sts_q;
	logic [31:0] mov_rdata_q;
	logic mov_fault_q;
	logic task_pend_q;
	logic [BDU_NUM_BP-1:0] match;
	logic [BDU_NUM_BP-1:0] enabled;
	logic priv_ok;
	logic mov_ok;
	logic step_exc;
	logic bp_exc;
	logic exc_taken;

	genvar gi;
	generate
		for (gi = 0; gi < BDU_NUM_BP; gi++) begin : g_bp
			bdu_match #(.AW(AW)) u_match (
				.bp_addr(addr_q[gi]),
				.type_field(ctl_q[BDU_CTL_TYPE_POS+gi*BDU_CTL_FIELD_STRIDE +: 2]),
				.len_field(ctl_q[BDU_CTL_LEN_POS+gi*BDU_CTL_FIELD_STRIDE +: 2]),
				.acc_valid(acc_valid),
				.acc_kind(acc_kind),
				.acc_addr(acc_addr),
				.hit(match[gi])
			);
			assign enabled[gi] = ctl_q[BDU_CTL_LOCAL_POS+2*gi] | ctl_q[BDU_CTL_GLOBAL_POS+2*gi];
		end
	endgenerate

	assign priv_ok = real_mode || (cur_cpl == 2'h0);
	// Guard bit refuses every move while set
	assign mov_ok = mov_valid && priv_ok && !ctl_q[BDU_CTL_GUARD_POS];

	assign bp_exc = |(match & enabled);
	assign step_exc = insn_done && flags_register[BDU_TRAP_FLAG_BIT];
	// Execute hits come with the fetch, ahead of execution
	assign dbg_exc_before = bp_exc && (acc_kind == BDU_ACC_FETCH);
	assign dbg_exc_after = step_exc || (bp_exc && (acc_kind != BDU_ACC_FETCH));
	assign bp_insn_exc = bp_insn_exec;
	assign exc_taken = bp_exc || step_exc;

	always_ff @(posedge mclk) begin
		if (srst) begin
			for (int i = 0; i < BDU_NUM_BP; i++) begin
				addr_q[i] <= AW'(BDU_ADDR_RESET);
			end
		end else if (mov_ok && mov_write && (mov_sel <= BDU_SEL_ADDR3)) begin
			addr_q[mov_sel[1:0]] <= mov_wdata[AW-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ctl_q <= BDU_CTL_RESET;
		end else begin
			logic [31:0] nxt;
			nxt = ctl_q;
			if (mov_ok && mov_write && mov_sel == BDU_SEL_CONTROL) begin
				nxt = (mov_wdata & BDU_CTL_WMASK) | BDU_CTL_RESET;
			end
			if (task_switch) begin
				for (int i = 0; i < BDU_NUM_BP; i++) begin
					nxt[BDU_CTL_LOCAL_POS+2*i] = 1'b0;
				end
			end
			if (exc_taken) begin
				nxt[BDU_CTL_GUARD_POS] = 1'b0;
			end
			ctl_q <= nxt;
		end
	end

	// Task-switch flag waits for the next debug exception to be recorded
	always_ff @(posedge mclk) begin
		if (srst) begin
			task_pend_q <= 1'b0;
		end else if (task_switch) begin
			task_pend_q <= new_task_trap;
		end else if (exc_taken) begin
			task_pend_q <= 1'b0;
		end
	end

	// Status only gains bits; moves never write it
	always_ff @(posedge mclk) begin
		if (srst) begin
			sts_q <= BDU_STS_RESET;
		end else if (exc_taken) begin
			sts_q[BDU_NUM_BP-1:0] <= sts_q[BDU_NUM_BP-1:0] | match;
			if (step_exc) begin
				sts_q[BDU_STS_STEP_POS] <= 1'b1;
			end
			if (task_pend_q) begin
				sts_q[BDU_STS_TASK_POS] <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			mov_rdata_q <= 32'h0;
			mov_fault_q <= 1'b0;
		end else begin
			mov_fault_q <= mov_valid && !mov_ok;
			if (mov_ok && !mov_write) begin
				unique case (mov_sel)
					BDU_SEL_ADDR0, BDU_SEL_ADDR1, BDU_SEL_ADDR2, BDU_SEL_ADDR3:
						mov_rdata_q <= 32'(addr_q[mov_sel[1:0]]);
					BDU_SEL_STATUS: mov_rdata_q <= sts_q;
					BDU_SEL_CONTROL: mov_rdata_q <= ctl_q;
					default: mov_rdata_q <= 32'h0;
				endcase
			end
		end
	end

	assign mov_rdata = mov_rdata_q;
	assign mov_fault = mov_fault_q;

	AST_LOCAL_CLEAR: assert property (@(posedge mclk) disable iff (srst)
		task_switch |=> (ctl_q[6] | ctl_q[4] | ctl_q[2] | ctl_q[0]) == 1'b0)
		else $error("local enable survived task switch");
	AST_GLOBAL_KEEP: assert property (@(posedge mclk) disable iff (srst)
		task_switch && !(mov_ok && mov_write && mov_sel == BDU_SEL_CONTROL)
		|=> ctl_q[1] == $past(ctl_q[1]))
		else $error("global enable lost on task switch");
	AST_GUARD_CLEAR: assert property (@(posedge mclk) disable iff (srst)
		exc_taken |=> !ctl_q[BDU_CTL_GUARD_POS])
		else $error("guard bit not cleared on exception");
	AST_HIT_RECORD: assert property (@(posedge mclk) disable iff (srst)
		exc_taken && match[0] |=> sts_q[0])
		else $error("hit bit not recorded");
	AST_STEP: assert property (@(posedge mclk) disable iff (srst)
		insn_done && flags_register[8] |-> dbg_exc_after ##1 sts_q[BDU_STS_STEP_POS])
		else $error("single step not raised");
	AST_STICKY: assert property (@(posedge mclk) disable iff (srst)
		sts_q[BDU_STS_STEP_POS] |=> sts_q[BDU_STS_STEP_POS])
		else $error("status cleared by hardware");
	AST_PRIV: assert property (@(posedge mclk) disable iff (srst)
		mov_valid && !real_mode && cur_cpl != 2'h0 |=> mov_fault)
		else $error("unprivileged move accepted");
	AST_EXEC_BEFORE: assert property (@(posedge mclk) disable iff (srst)
		acc_valid && acc_kind == BDU_ACC_FETCH && |(match & enabled) |-> dbg_exc_before)
		else $error("execute breakpoint missed");
	AST_STS_RO: assert property (@(posedge mclk) disable iff (srst)
		!exc_taken |=> sts_q == $past(sts_q))
		else $error("status changed without exception");
	AST_BREAKPOINT_INSTRUCTION: assert property (@(posedge mclk) disable iff (srst)
		bp_insn_exec |-> bp_insn_exc)
		else $error("breakpoint instruction ignored");
	// Fixed status bits must never move, whatever the exceptions do
	AST_STS_FIXED: assert property (@(posedge mclk) disable iff (srst)
		sts_q[12:4] == 9'h1ff && !sts_q[13] && sts_q[31:16] == 16'h0)
		else $error("fixed status bits changed");
	AST_CTL_FIXED: assert property (@(posedge mclk) disable iff (srst)
		ctl_q[10] && ctl_q[15:14] == 2'h0 && !ctl_q[12] && !ctl_q[11] && ctl_q[9:8] == 2'h0)
		else $error("fixed control bits changed");
	AST_GUARD_BLOCK: assert property (@(posedge mclk) disable iff (srst)
		mov_valid && ctl_q[BDU_CTL_GUARD_POS] |=> mov_fault)
		else $error("move accepted while guarded");
	AST_FAULT_SRC: assert property (@(posedge mclk) disable iff (srst)
		mov_fault |-> $past(mov_valid))
		else $error("fault without a move");
	AST_RDATA_HOLD: assert property (@(posedge mclk) disable iff (srst)
		!(mov_valid && !mov_write) |=> $stable(mov_rdata))
		else $error("read data moved without a read");
	AST_BEFORE_SRC: assert property (@(posedge mclk) disable iff (srst)
		dbg_exc_before |-> acc_valid && acc_kind == BDU_ACC_FETCH)
		else $error("early exception without a fetch");
	AST_QUIET: assert property (@(posedge mclk) disable iff (srst)
		!acc_valid && !insn_done |-> !dbg_exc_before && !dbg_exc_after)
		else $error("exception without a cause");
	AST_TASK_HIT: assert property (@(posedge mclk) disable iff (srst)
		task_pend_q && exc_taken |=> sts_q[BDU_STS_TASK_POS])
		else $error("task switch hit not recorded");

	COV_EXEC_BP: cover property (@(posedge mclk) disable iff (srst) dbg_exc_before);
	COV_STEP: cover property (@(posedge mclk) disable iff (srst) step_exc);
	COV_TASK: cover property (@(posedge mclk) disable iff (srst) task_switch ##[1:5] exc_taken);
	COV_FAULT: cover property (@(posedge mclk) disable iff (srst) mov_fault);
	COV_DATA_BP: cover property (@(posedge mclk) disable iff (srst) bp_exc && !step_exc);
endmodule

/* rtl/bdu_match.sv */
// One breakpoint comparator: address masked by length, access type filter.
`timescale 1ns/1ps
module bdu_match
	import bdu_pkg::*;
#(
	parameter int AW = 32
) (
	input wire logic [AW-1:0] bp_addr,
	input wire logic [1:0] type_field,
	input wire logic [1:0] len_field,
	input wire logic acc_valid,
	input wire logic [1:0] acc_kind,
	input wire logic [AW-1:0] acc_addr,
	output logic hit
);
	logic [AW-1:0] mask;
	logic type_ok;

	always_comb begin
		// Code 10 is unused; treated as one byte so it never widens the window
		unique case (len_field)
			BDU_LEN_2: mask = {{(AW-1){1'b1}}, 1'b0};
			BDU_LEN_4: mask = {{(AW-2){1'b1}}, 2'b00};
			default: mask = '1;
		endcase
	end

	always_comb begin
		unique case (type_field)
			BDU_TYPE_EXEC: type_ok = (acc_kind == BDU_ACC_FETCH);
			BDU_TYPE_WRITE: type_ok = (acc_kind == BDU_ACC_WRITE);
			BDU_TYPE_RDWR: type_ok = (acc_kind == BDU_ACC_READ) || (acc_kind == BDU_ACC_WRITE);
			default: type_ok = 1'b0;
		endcase
	end

	assign hit = acc_valid && type_ok && ((acc_addr & mask) == (bp_addr & mask));
endmodule

/* rtl/bdu_pkg.sv */
// Constants for the breakpoint debug unit: register selects, field layout, reset values.
package bdu_pkg;
	localparam int BDU_NUM_BP = 4;
	// Register selects of the privileged move port
	localparam logic [2:0] BDU_SEL_ADDR0 = 3'h0;
	localparam logic [2:0] BDU_SEL_ADDR1 = 3'h1;
	localparam logic [2:0] BDU_SEL_ADDR2 = 3'h2;
	localparam logic [2:0] BDU_SEL_ADDR3 = 3'h3;
	localparam logic [2:0] BDU_SEL_STATUS = 3'h6;
	localparam logic [2:0] BDU_SEL_CONTROL = 3'h7;
	// debug_control layout
	localparam int BDU_CTL_LOCAL_POS = 0;
	localparam int BDU_CTL_GLOBAL_POS = 1;
	localparam int BDU_CTL_GUARD_POS = 13;
	localparam int BDU_CTL_TYPE_POS = 16;
	localparam int BDU_CTL_LEN_POS = 18;
	localparam int BDU_CTL_FIELD_STRIDE = 4;
	localparam logic [31:0] BDU_CTL_WMASK = 32'hffff20ff;
	localparam logic [31:0] BDU_CTL_RESET = 32'h00000400;
	// debug_status layout
	localparam int BDU_STS_TASK_POS = 15;
	localparam int BDU_STS_STEP_POS = 14;
	// Bits 12 to 4 read as ones, bit 13 and the upper half as zero
	localparam logic [31:0] BDU_STS_RESET = 32'h00001ff0;
	localparam logic [31:0] BDU_ADDR_RESET = 32'h00000000;
	// Access types and lengths
	localparam logic [1:0] BDU_TYPE_EXEC = 2'h0;
	localparam logic [1:0] BDU_TYPE_WRITE = 2'h1;
	localparam logic [1:0] BDU_TYPE_RDWR = 2'h3;
	localparam logic [1:0] BDU_LEN_1 = 2'h0;
	localparam logic [1:0] BDU_LEN_2 = 2'h1;
	localparam logic [1:0] BDU_LEN_4 = 2'h3;
	// Core access kinds on acc_kind
	localparam logic [1:0] BDU_ACC_FETCH = 2'h0;
	localparam logic [1:0] BDU_ACC_READ = 2'h1;
	localparam logic [1:0] BDU_ACC_WRITE = 2'h2;
	localparam int BDU_TRAP_FLAG_BIT = 8;
endpackage

/* tb/bdu_pipe_model.sv */
// Core pipeline stand-in: drives accesses and events, captures exception requests.
`timescale 1ns/1ps
module bdu_pipe_model
	import bdu_pkg::*;
(
	input wire logic mclk,
	output logic acc_valid,
	output logic [1:0] acc_kind,
	output logic [31:0] acc_addr,
	output logic insn_done,
	output logic [31:0] flags_register,
	output logic bp_insn_exec,
	output logic task_switch,
	output logic new_task_trap,
	input wire logic dbg_exc_before,
	input wire logic dbg_exc_after,
	input wire logic bp_insn_exc,
	output logic [2:0] seen
);
	initial begin
		{acc_valid, insn_done, bp_insn_exec, task_switch, new_task_trap} = 5'h00;
		acc_kind = 2'h0;
		acc_addr = 32'h0;
		flags_register = 32'h00000002;
		seen = 3'h0;
	end
	// ev: access, done, trap flag, breakpoint insn, task switch, new task trap
	task automatic pulse(input logic [5:0] ev, input logic [1:0] kind, input logic [31:0] addr);
		@(posedge mclk);
		{acc_valid, insn_done, flags_register[BDU_TRAP_FLAG_BIT]} <= ev[5:3];
		{bp_insn_exec, task_switch, new_task_trap} <= ev[2:0];
		acc_kind <= kind;
		acc_addr <= addr;
		#1;
		seen = {dbg_exc_before, dbg_exc_after, bp_insn_exc};
		@(posedge mclk);
		{acc_valid, insn_done, flags_register[BDU_TRAP_FLAG_BIT]} <= 3'h0;
		{bp_insn_exec, task_switch, new_task_trap} <= 3'h0;
		// Released bus shows the inverse so a stale address cannot match
		acc_addr <= ~addr;
	endtask
endmodule

/* tb/breakpoint_debug_unit_tb.sv */
// Self-checking bench for the breakpoint debug unit.
`timescale 1ns/1ps
module breakpoint_debug_unit_tb
	import bdu_pkg::*;
;
	logic mclk = 1'b0, srst = 1'b1, mov_valid = 1'b0, mov_write = 1'b0, real_mode = 1'b0;
	logic [2:0] mov_sel = 3'h0;
	logic [31:0] mov_wdata = 32'h0, mov_rdata, acc_addr, flags_register, sts, rd;
	logic [1:0] cur_cpl = 2'h0, acc_kind;
	logic mov_fault, acc_valid, insn_done, bp_insn_exec, task_switch, new_task_trap, flt;
	logic dbg_exc_before, dbg_exc_after, bp_insn_exc;
	logic [2:0] seen;
	int errors = 0, checks_done = 0;

	bdu_core bdu_core_i (.mclk(mclk), .srst(srst), .mov_valid(mov_valid), .mov_write(mov_write),
		.mov_sel(mov_sel), .mov_wdata(mov_wdata), .cur_cpl(cur_cpl), .real_mode(real_mode),
		.mov_rdata(mov_rdata), .mov_fault(mov_fault), .acc_valid(acc_valid),
		.acc_kind(acc_kind), .acc_addr(acc_addr), .insn_done(insn_done),
		.flags_register(flags_register), .bp_insn_exec(bp_insn_exec),
		.task_switch(task_switch), .new_task_trap(new_task_trap),
		.dbg_exc_before(dbg_exc_before), .dbg_exc_after(dbg_exc_after),
		.bp_insn_exc(bp_insn_exc));
	bdu_pipe_model bdu_pipe_model_i (.mclk(mclk), .acc_valid(acc_valid), .acc_kind(acc_kind),
		.acc_addr(acc_addr), .insn_done(insn_done), .flags_register(flags_register),
		.bp_insn_exec(bp_insn_exec), .task_switch(task_switch),
		.new_task_trap(new_task_trap), .dbg_exc_before(dbg_exc_before),
		.dbg_exc_after(dbg_exc_after), .bp_insn_exc(bp_insn_exc), .seen(seen));

	initial begin
		forever #2.5 mclk = ~mclk;
	end

	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic mov(input logic wr, input logic [2:0] sel, input logic [31:0] d);
		@(posedge mclk);
		mov_valid <= 1'b1;
		mov_write <= wr;
		mov_sel <= sel;
		mov_wdata <= d;
		@(posedge mclk);
		mov_valid <= 1'b0;
		mov_wdata <= ~d;
		#1;
		rd = mov_rdata;
		flt = mov_fault;
	endtask

	task automatic rdchk(input logic [2:0] sel, input logic [31:0] exp);
		mov(1'b0, sel, 32'h0);
		check({flt, rd}, {1'b0, exp});
	endtask

	task automatic end_of_test;
		$display("checks_done %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		#20000;
		errors++;
		end_of_test;
	end

	initial begin
		sts = BDU_STS_RESET;
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		rdchk(BDU_SEL_CONTROL, BDU_CTL_RESET);
		rdchk(BDU_SEL_STATUS, sts);
		for (int i = 0; i < 4; i++) begin
			rdchk(3'(i), BDU_ADDR_RESET);
			mov(1'b1, 3'(i), 32'h1000 << i);
			rdchk(3'(i), 32'h1000 << i);
		end
		rdchk(3'h4, 32'h0);
		mov(1'b1, BDU_SEL_STATUS, 32'h0);
		rdchk(BDU_SEL_STATUS, sts);
		cur_cpl <= 2'h3;
		mov(1'b1, BDU_SEL_CONTROL, 32'h00000001);
		check(33'(flt), 33'h1);
		real_mode <= 1'b1;
		mov(1'b1, BDU_SEL_CONTROL, 32'h00000001);
		check(33'(flt), 33'h0);
		real_mode <= 1'b0;
		cur_cpl <= 2'h0;
		rdchk(BDU_SEL_CONTROL, 32'h00000401);
		bdu_pipe_model_i.pulse(6'h20, BDU_ACC_FETCH, 32'h1001);
		check(33'(seen), 33'h0);
		bdu_pipe_model_i.pulse(6'h20, BDU_ACC_FETCH, 32'h1000);
		check(33'(seen), 33'h4);
		sts = sts | 32'h1;
		rdchk(BDU_SEL_STATUS, sts);
		// Keep L0, add global bp1 watching writes over four bytes
		mov(1'b1, BDU_SEL_CONTROL, 32'h00d00009);
		rdchk(BDU_SEL_CONTROL, 32'h00d00409);
		bdu_pipe_model_i.pulse(6'h20, BDU_ACC_READ, 32'h2003);
		check(33'(seen), 33'h0);
		bdu_pipe_model_i.pulse(6'h20, BDU_ACC_WRITE, 32'h2004);
		check(33'(seen), 33'h0);
		bdu_pipe_model_i.pulse(6'h20, BDU_ACC_WRITE, 32'h2003);
		check(33'(seen), 33'h2);
		sts = sts | 32'h2;
		bdu_pipe_model_i.pulse(6'h03, BDU_ACC_FETCH, 32'h0);
		rdchk(BDU_SEL_CONTROL, 32'h00d00408);
		bdu_pipe_model_i.pulse(6'h04, BDU_ACC_FETCH, 32'h0);
		check(33'(seen), 33'h1);
		// bp2 is disabled yet matches this fetch during a single step
		bdu_pipe_model_i.pulse(6'h38, BDU_ACC_FETCH, 32'h4000);
		check(33'(seen), 33'h2);
		sts = sts | 32'h0000c004;
		rdchk(BDU_SEL_STATUS, sts);
		mov(1'b1, BDU_SEL_CONTROL, 32'h00002000);
		mov(1'b0, BDU_SEL_CONTROL, 32'h0);
		check(33'(flt), 33'h1);
		bdu_pipe_model_i.pulse(6'h18, BDU_ACC_FETCH, 32'h0);
		check(33'(seen), 33'h2);
		rdchk(BDU_SEL_CONTROL, 32'h00000400);
		rdchk(BDU_SEL_STATUS, sts);
		end_of_test;
	end
endmodule
